// file: src/cdcfg_top.v
// APB register bank and interrupt logic for the current-detect function
`timescale 1ns/1ns
module cdcfg_top #(
  parameter NCH = 4
) (
  input  wire            core_clk_in,
  input  wire            rst_b_in,
  input  wire            psel_in,
  input  wire            penable_in,
  input  wire            pwrite_in,
  input  wire [7:0]      paddr_in,
  input  wire [31:0]     pwdata_in,
  output reg  [31:0]     prdata_out,
  output reg             pready_out,
  output reg             pslverr_out,
  input  wire            sample_valid_in,
  input  wire [NCH*24-1:0] sample_data_in,
  output reg             detect_mode_on_out,
  output reg  [3:0]      dc_removal_coefficient_out,
  output reg             detect_flag_out,
  output reg             irq_out
);
`include "cdcfg_map.vh"

  // ----------------------------------------------------------------------
  // Reset release synchroniser
  // ----------------------------------------------------------------------
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg  [15:0] config_r;
  reg  [15:0] thr_high_r;
  reg  [15:0] thr_low_r;
  reg  [`CDCFG_IRQ_W-1:0] irq_status_r;
  reg  [`CDCFG_IRQ_W-1:0] irq_mask_r;

  wire        exceed_pulse_w;
  wire        window_done_w;
  wire        det_flag_w;

  // Field views
  wire        all_channels_required = config_r[`CDCFG_CFG_ALLCH_BIT];
  wire [2:0]  exceed_count_select   = config_r[`CDCFG_CFG_NUM_HI:`CDCFG_CFG_NUM_LO];
  wire [2:0]  detect_window_length  = config_r[`CDCFG_CFG_LEN_HI:`CDCFG_CFG_LEN_LO];
  wire        detect_mode_on        = config_r[`CDCFG_CFG_EN_BIT];
  wire [7:0]  threshold_lower_byte  = thr_low_r[`CDCFG_LOW_TH_HI:`CDCFG_LOW_TH_LO];
  wire [15:0] threshold_upper_bits  = thr_high_r;

  // 24-bit threshold from both words
  wire [23:0] threshold_w = {threshold_upper_bits, threshold_lower_byte};

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire        acc_w    = psel_in & penable_in & pready_out;
  wire        wr_w     = acc_w & pwrite_in;
  wire [5:0]  word_w   = paddr_in[7:2];
  wire        aligned_w = paddr_in[1:0] == 2'b00;
  wire        hit_cfg_w = aligned_w & (word_w == {2'b00, `CDCFG_IDX_CONFIG});
  wire        hit_thh_w = aligned_w & (word_w == {2'b00, `CDCFG_IDX_THR_HIGH});
  wire        hit_thl_w = aligned_w & (word_w == {2'b00, `CDCFG_IDX_THR_LOW});
  wire        hit_ist_w = aligned_w & (word_w == {2'b00, `CDCFG_IDX_IRQ_STATUS});
  wire        hit_imk_w = aligned_w & (word_w == {2'b00, `CDCFG_IDX_IRQ_MASK});
  wire        hit_dst_w = aligned_w & (word_w == {2'b00, `CDCFG_IDX_DET_STATUS});
  wire        mapped_w  = hit_cfg_w | hit_thh_w | hit_thl_w | hit_ist_w | hit_imk_w | hit_dst_w;

  // Read mux
  reg  [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (hit_cfg_w) begin
      rdata_nxt = {16'h0000, config_r};
    end else if (hit_thh_w) begin
      rdata_nxt = {16'h0000, thr_high_r};
    end else if (hit_thl_w) begin
      rdata_nxt = {16'h0000, thr_low_r & `CDCFG_LOW_RW_MASK};
    end else if (hit_ist_w) begin
      rdata_nxt = {30'h0000_0000, irq_status_r};
    end else if (hit_imk_w) begin
      rdata_nxt = {30'h0000_0000, irq_mask_r};
    end else if (hit_dst_w) begin
      rdata_nxt = {31'h0000_0000, det_flag_w};
    end
  end

  // ----------------------------------------------------------------------
  // APB answer: one wait state, pready high in second access cycle
  // ----------------------------------------------------------------------
  always @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      if (psel_in && penable_in && !pready_out) begin
        pready_out  <= 1'b1;
        prdata_out  <= pwrite_in ? 32'h0000_0000 : rdata_nxt;
        pslverr_out <= ~mapped_w;
      end else begin
        pready_out  <= 1'b0;
        prdata_out  <= 32'h0000_0000;
        pslverr_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      config_r   <= `CDCFG_RST_CONFIG;
      thr_high_r <= `CDCFG_RST_THR_HIGH;
      thr_low_r  <= `CDCFG_RST_THR_LOW;
      irq_mask_r <= {`CDCFG_IRQ_W{1'b0}};
    end else if (wr_w) begin
      if (hit_cfg_w) begin
        config_r <= pwdata_in[15:0];
      end
      if (hit_thh_w) begin
        thr_high_r <= pwdata_in[15:0];
      end
      if (hit_thl_w) begin
        thr_low_r <= pwdata_in[15:0] & `CDCFG_LOW_RW_MASK;
      end
      if (hit_imk_w) begin
        irq_mask_r <= pwdata_in[`CDCFG_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sticky interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------------
  wire [`CDCFG_IRQ_W-1:0] irq_set_w = {window_done_w, exceed_pulse_w};
  wire [`CDCFG_IRQ_W-1:0] irq_clr_w = (wr_w & hit_ist_w) ?
                                      pwdata_in[`CDCFG_IRQ_W-1:0] : {`CDCFG_IRQ_W{1'b0}};
  always @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      irq_status_r <= {`CDCFG_IRQ_W{1'b0}};
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr_w) | irq_set_w;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      detect_mode_on_out         <= 1'b0;
      dc_removal_coefficient_out <= 4'h0;
      detect_flag_out            <= 1'b0;
      irq_out                    <= 1'b0;
    end else begin
      detect_mode_on_out         <= detect_mode_on;
      dc_removal_coefficient_out <= thr_low_r[`CDCFG_LOW_DC_HI:`CDCFG_LOW_DC_LO];
      detect_flag_out            <= det_flag_w;
      irq_out                    <= |(irq_status_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------------
  // Detection engine
  // ----------------------------------------------------------------------
  cdcfg_detect #(
    .NCH (NCH),
    .DW  (24)
  ) u_detect (
    .clk_in                   (core_clk_in),
    .rst_b_in                 (rst_sync_r),
    .enable_in                (detect_mode_on),
    .all_channels_required_in (all_channels_required),
    .exceed_count_select_in   (exceed_count_select),
    .detect_window_length_in  (detect_window_length),
    .threshold_in             (threshold_w),
    .sample_valid_in          (sample_valid_in),
    .sample_data_in           (sample_data_in),
    .detect_pulse_out         (exceed_pulse_w),
    .window_done_out          (window_done_w),
    .detect_flag_out          (det_flag_w)
  );
endmodule

// file: src/cdcfg_map.vh
// Register map, field positions, reset values and timing counts for current-detect config
`ifndef CDCFG_MAP_VH
`define CDCFG_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CDCFG_IDX_CONFIG      4'h6
`define CDCFG_IDX_THR_HIGH    4'h7
`define CDCFG_IDX_THR_LOW     4'h8
`define CDCFG_IDX_IRQ_STATUS  4'hC
`define CDCFG_IDX_IRQ_MASK    4'hD
`define CDCFG_IDX_DET_STATUS  4'hE

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CDCFG_RST_CONFIG      16'h0600
`define CDCFG_RST_THR_HIGH    16'h0000
`define CDCFG_RST_THR_LOW     16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CDCFG_CFG_ALLCH_BIT   7
`define CDCFG_CFG_NUM_HI      6
`define CDCFG_CFG_NUM_LO      4
`define CDCFG_CFG_LEN_HI      3
`define CDCFG_CFG_LEN_LO      1
`define CDCFG_CFG_EN_BIT      0
`define CDCFG_LOW_TH_HI       15
`define CDCFG_LOW_TH_LO       8
`define CDCFG_LOW_DC_HI       3
`define CDCFG_LOW_DC_LO       0
`define CDCFG_LOW_RW_MASK     16'hFF0F

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define CDCFG_IRQ_DETECT_BIT  0
`define CDCFG_IRQ_WINDOW_BIT  1
`define CDCFG_IRQ_W           2

// ----------------------------------------------------------------------
// Window lengths in conversion periods
// ----------------------------------------------------------------------
`define CDCFG_LEN_0           12'h080
`define CDCFG_LEN_1           12'h100
`define CDCFG_LEN_2           12'h200
`define CDCFG_LEN_3           12'h300
`define CDCFG_LEN_4           12'h500
`define CDCFG_LEN_5           12'h700
`define CDCFG_LEN_6           12'hA00
`define CDCFG_LEN_7           12'hE00

`endif

// file: src/cdcfg_detect.v
// Threshold comparison and exceedance counting over a measurement window
`timescale 1ns/1ns
module cdcfg_detect #(
  parameter NCH = 4,
  parameter DW  = 24
) (
  input  wire              clk_in,
  input  wire              rst_b_in,
  input  wire              enable_in,
  input  wire              all_channels_required_in,
  input  wire [2:0]        exceed_count_select_in,
  input  wire [2:0]        detect_window_length_in,
  input  wire [DW-1:0]     threshold_in,
  input  wire              sample_valid_in,
  input  wire [NCH*DW-1:0] sample_data_in,
  output reg               detect_pulse_out,
  output reg               window_done_out,
  output reg               detect_flag_out
);
`include "cdcfg_map.vh"

  // ----------------------------------------------------------------------
  // Per-channel comparison
  // ----------------------------------------------------------------------
  wire [NCH-1:0] over_w;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_cmp
      // Magnitude compare, threshold taken as unsigned
      assign over_w[g] = sample_data_in[g*DW +: DW] > threshold_in;
    end
  endgenerate

  // Any or all channels over threshold
  wire hit_w = all_channels_required_in ? &over_w : |over_w;

  // ----------------------------------------------------------------------
  // Window length and target count decode
  // ----------------------------------------------------------------------
  reg [11:0] win_len_w;
  always @* begin
    case (detect_window_length_in)
      3'd0:    win_len_w = `CDCFG_LEN_0;
      3'd1:    win_len_w = `CDCFG_LEN_1;
      3'd2:    win_len_w = `CDCFG_LEN_2;
      3'd3:    win_len_w = `CDCFG_LEN_3;
      3'd4:    win_len_w = `CDCFG_LEN_4;
      3'd5:    win_len_w = `CDCFG_LEN_5;
      3'd6:    win_len_w = `CDCFG_LEN_6;
      default: win_len_w = `CDCFG_LEN_7;
    endcase
  end
  wire [7:0] target_w = 8'h01 << exceed_count_select_in;

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  reg  [11:0] period_cnt_r;
  reg  [7:0]  hit_cnt_r;
  reg         reached_r;
  wire        last_w    = period_cnt_r == win_len_w - 12'h001;
  wire        hit_now_w = sample_valid_in & hit_w;
  wire        reach_w   = hit_now_w & ~reached_r & (hit_cnt_r + 8'h01 >= target_w);

  // Count exceedances, restart each window; flag once target reached
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      period_cnt_r     <= 12'h000;
      hit_cnt_r        <= 8'h00;
      reached_r        <= 1'b0;
      detect_pulse_out <= 1'b0;
      window_done_out  <= 1'b0;
      detect_flag_out  <= 1'b0;
    end else if (!enable_in) begin
      period_cnt_r     <= 12'h000;
      hit_cnt_r        <= 8'h00;
      reached_r        <= 1'b0;
      detect_pulse_out <= 1'b0;
      window_done_out  <= 1'b0;
      detect_flag_out  <= 1'b0;
    end else begin
      detect_pulse_out <= reach_w;
      window_done_out  <= sample_valid_in & last_w;
      if (reach_w) begin
        detect_flag_out <= 1'b1;
      end
      if (sample_valid_in) begin
        if (last_w) begin
          period_cnt_r <= 12'h000;
          hit_cnt_r    <= 8'h00;
          reached_r    <= 1'b0;
        end else begin
          period_cnt_r <= period_cnt_r + 12'h001;
          if (hit_now_w && hit_cnt_r != 8'hFF) begin
            hit_cnt_r <= hit_cnt_r + 8'h01;
          end
          if (reach_w) begin
            reached_r <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// file: dv/cdcfg_top_sva.sv
// Port-level assertion checker for the current-detect register bank
`timescale 1ns/1ns
module cdcfg_sva_chk #(
  parameter NCH = 4
) (
  input wire              core_clk_in,
  input wire              rst_b_in,
  input wire              psel_in,
  input wire              penable_in,
  input wire              pwrite_in,
  input wire [7:0]        paddr_in,
  input wire [31:0]       pwdata_in,
  input wire [31:0]       prdata_out,
  input wire              pready_out,
  input wire              pslverr_out,
  input wire              sample_valid_in,
  input wire [NCH*24-1:0] sample_data_in,
  input wire              detect_mode_on_out,
  input wire [3:0]        dc_removal_coefficient_out,
  input wire              detect_flag_out,
  input wire              irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  // --------------------------------------------------------------------
  // Completed writes to config and low threshold word
  // --------------------------------------------------------------------
  wire cfg_wr_w = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h18;
  wire low_wr_w = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h20;

  // --------------------------------------------------------------------
  // Bus timing and register reads
  // --------------------------------------------------------------------
  ready_one_wait_a: assert property (
    (psel_in && penable_in && !pready_out) |=> pready_out) else $error("no ready after access");
  ready_pulse_a: assert property (
    pready_out |=> !pready_out) else $error("ready held too long");
  error_with_ready_a: assert property (
    pslverr_out |-> pready_out) else $error("error without ready");
  idle_data_zero_a: assert property (
    !pready_out |-> prdata_out == 32'h0000_0000) else $error("read data outside ready");
  reserved_nibble_a: assert property (
    (pready_out && !pwrite_in && paddr_in == 8'h20) |-> prdata_out[7:4] == 4'h0)
    else $error("reserved nibble not zero");

  // --------------------------------------------------------------------
  // Outputs follow their register writes and detection
  // --------------------------------------------------------------------
  mode_follows_write_a: assert property (
    $changed(detect_mode_on_out) |-> $past(cfg_wr_w) || $past(cfg_wr_w, 2))
    else $error("mode changed without config write");
  dc_follows_write_a: assert property (
    $changed(dc_removal_coefficient_out) |-> $past(low_wr_w) || $past(low_wr_w, 2))
    else $error("filter setting changed without write");
  flag_needs_mode_a: assert property (
    $rose(detect_flag_out) |-> detect_mode_on_out && $past(sample_valid_in, 2))
    else $error("flag rose without enabled sample");
  flag_clear_off_a: assert property (
    $fell(detect_flag_out) |-> ##[0:2] !detect_mode_on_out)
    else $error("flag cleared while mode on");
endmodule

bind cdcfg_top cdcfg_sva_chk #(.NCH(NCH)) cdcfg_sva_chk_i (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .sample_valid_in(sample_valid_in),
  .sample_data_in(sample_data_in), .detect_mode_on_out(detect_mode_on_out),
  .dc_removal_coefficient_out(dc_removal_coefficient_out),
  .detect_flag_out(detect_flag_out), .irq_out(irq_out)
);

// file: dv/test_current_detect_config.sv
// Self-checking bench for the current-detect register bank
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module test_current_detect_config;
  logic        core_clk_in     = 1'b0;
  logic        rst_b_in        = 1'b0;
  logic        psel_in         = 1'b0;
  logic        penable_in      = 1'b0;
  logic        pwrite_in       = 1'b0;
  logic [7:0]  paddr_in        = 8'h00;
  logic [31:0] pwdata_in       = 32'h0000_0000;
  logic        sample_valid_in = 1'b0;
  logic [95:0] sample_data_in  = 96'h0;
  wire  [31:0] prdata_out;
  wire         pready_out;
  wire         pslverr_out;
  wire         detect_mode_on_out;
  wire  [3:0]  dc_removal_coefficient_out;
  wire         detect_flag_out;
  wire         irq_out;
  int          miscompares     = 0;
  int          checks          = 0;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [31:0] r;
  int          k;
  int          lens[8]         = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};

  // 25 MHz clock
  always #20 core_clk_in = ~core_clk_in;

  cdcfg_top #(.NCH(4)) cdcfg_top_i (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .sample_valid_in(sample_valid_in),
    .sample_data_in(sample_data_in), .detect_mode_on_out(detect_mode_on_out),
    .dc_removal_coefficient_out(dc_removal_coefficient_out),
    .detect_flag_out(detect_flag_out), .irq_out(irq_out)
  );

  // Closing report
  task give_verdict;
    $display("Counts: checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; d is write data or expected read data
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    notes.push_back({~w, err, w ? 32'h0000_0000 : d});
    @(posedge core_clk_in);
    psel_in   <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= w ? d : 32'h0000_0000;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      give_verdict;
    end
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // One conversion period, then time for flag and interrupt to settle
  task send(input logic [95:0] d);
    @(posedge core_clk_in);
    sample_valid_in <= 1'b1;
    sample_data_in  <= d;
    @(posedge core_clk_in);
    sample_valid_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
  endtask

  // Response monitor against queued notes
  always @(posedge core_clk_in) begin
    if (pready_out === 1'b1) begin
      note = notes.pop_front();
      `CHK("pslverr", note[32], pslverr_out)
      if (note[33]) `CHK("prdata", note[31:0], prdata_out)
    end
  end

  // Hang guard
  initial begin
    repeat (30000) @(posedge core_clk_in);
    miscompares++;
    give_verdict;
  end

  // Main sequence
  initial begin
    void'($urandom(7382));
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    apb(0, 8'h18, 32'h0000_0600, 0);
    apb(0, 8'h1C, 32'h0000_0000, 0);
    apb(0, 8'h20, 32'h0000_0000, 0);
    r = $urandom;
    apb(1, 8'h1C, {16'h0000, r[15:0]}, 0);
    apb(0, 8'h1C, {16'h0000, r[15:0]}, 0);
    r = $urandom;
    apb(1, 8'h20, {16'h0000, r[15:0]}, 0);
    apb(0, 8'h20, {16'h0000, r[15:0] & 16'hFF0F}, 0);
    repeat (2) @(posedge core_clk_in);
    `CHK("dc_coef", r[3:0], dc_removal_coefficient_out)
    r = $urandom & 32'h0000_FFFE;
    apb(1, 8'h18, r, 0);
    apb(0, 8'h18, r, 0);
    apb(0, 8'h3C, 32'h0000_0000, 1);
    apb(1, 8'h3C, r, 1);
    apb(1, 8'h1C, 32'h0000_1234, 0);
    apb(1, 8'h20, 32'h0000_5600, 0);
    apb(1, 8'h34, 32'h0000_0001, 0);
    apb(1, 8'h18, 32'h0000_0011, 0);
    send({4{24'h12_3456}});
    `CHK("mode", 1'b1, detect_mode_on_out)
    `CHK("flag", 1'b0, detect_flag_out)
    send({72'h0, 24'h12_3457});
    `CHK("flag", 1'b0, detect_flag_out)
    send({72'h0, 24'h12_3457});
    `CHK("flag", 1'b1, detect_flag_out)
    `CHK("irq", 1'b1, irq_out)
    apb(0, 8'h38, 32'h0000_0001, 0);
    apb(1, 8'h30, 32'h0000_0001, 0);
    repeat (2) @(posedge core_clk_in);
    `CHK("irq", 1'b0, irq_out)
    repeat (124) send(96'h0);
    apb(0, 8'h30, 32'h0000_0000, 0);
    send(96'h0);
    apb(0, 8'h30, 32'h0000_0002, 0);
    apb(1, 8'h18, 32'h0000_0010, 0);
    repeat (3) @(posedge core_clk_in);
    `CHK("flag", 1'b0, detect_flag_out)
    `CHK("mode", 1'b0, detect_mode_on_out)
    apb(1, 8'h18, 32'h0000_0081, 0);
    send({72'h0, 24'hFF_FFFF});
    `CHK("flag", 1'b0, detect_flag_out)
    send({4{24'hFF_FFFF}});
    `CHK("flag", 1'b1, detect_flag_out)
    // Every exceedance count code: one hit short (codes 1 to 7), then the hit that reaches it
    for (k = 0; k < 8; k++) begin
      apb(1, 8'h18, 32'h0000_0000, 0);
      apb(1, 8'h18, {25'h0, k[2:0], 4'hF}, 0);
      if (k > 0) begin
        @(posedge core_clk_in);
        sample_data_in  <= {4{24'hFF_FFFF}};
        sample_valid_in <= 1'b1;
        repeat ((1 << k) - 1) @(posedge core_clk_in);
        sample_valid_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        `CHK("flag_short", 1'b0, detect_flag_out)
      end
      send({4{24'hFF_FFFF}});
      `CHK("flag_count", 1'b1, detect_flag_out)
    end
    // Every window length code: no window end one period early, end at the last
    for (k = 0; k < 8; k++) begin
      apb(1, 8'h18, 32'h0000_0000, 0);
      apb(1, 8'h18, {28'h0, k[2:0], 1'b1}, 0);
      apb(1, 8'h30, 32'h0000_0003, 0);
      @(posedge core_clk_in);
      sample_data_in  <= 96'h0;
      sample_valid_in <= 1'b1;
      repeat (lens[k] - 1) @(posedge core_clk_in);
      sample_valid_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      apb(0, 8'h30, 32'h0000_0000, 0);
      send(96'h0);
      apb(0, 8'h30, 32'h0000_0002, 0);
    end
    give_verdict;
  end
endmodule
